// [rtl/mpi_pkg.sv]
package mpi_pkg;

    // ***************************************************************
    // timing
    // ***************************************************************
    localparam int CLK_HZ      = 50_000_000;
    localparam int MII100_HZ   = 25_000_000;
    localparam int MII10_HZ    = 2_500_000;
    localparam int RMII_REF_HZ = 50_000_000;
    localparam int RMII10_HOLD = 10;
    localparam int DIV_W       = 5;
    localparam int DIV_MII100  = CLK_HZ / MII100_HZ;
    localparam int DIV_MII10   = CLK_HZ / MII10_HZ;
    localparam int DIV_RMII100 = CLK_HZ / RMII_REF_HZ;
    localparam int DIV_RMII10  = DIV_RMII100 * RMII10_HOLD;

    // ***************************************************************
    // straps, sampled from the receive data pins
    // ***************************************************************
    localparam int         STRAP_SPEED = 0;
    localparam int         STRAP_MODE  = 1;
    localparam int         STRAP_TYPE  = 2;
    localparam logic [1:0] ITYPE_MII   = 2'h1;
    localparam logic [1:0] ITYPE_RMII  = 2'h2;
    localparam logic [3:0] OE_MII      = 4'hf;
    localparam logic [3:0] OE_RMII     = 4'h3;
    localparam logic [3:0] OE_NONE     = 4'h0;

    // ***************************************************************
    // register map
    // ***************************************************************
    localparam int         ADR_W      = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EVENT  = 8'h08;
    localparam logic [7:0] REG_FRAMES = 8'h0c;
    localparam int         CTRL_EG_EN = 0;
    localparam int         CTRL_IG_EN = 1;
    localparam int         CTRL_HALF  = 2;
    localparam logic [2:0] CTRL_RST   = 3'h3;
    localparam int         EVT_COL    = 0;
    localparam int         EVT_ERR    = 1;

    typedef struct packed {
        logic       sof;
        logic       last;
        logic       err;
        logic [3:0] data;
    } mpi_nib_type;

    typedef enum {
        MD_STRAP,
        MD_MII_PHY,
        MD_MII_MAC,
        MD_RMII_NORM,
        MD_RMII_CLK,
        MD_IDLE
    } mpi_mode_type;

endpackage : mpi_pkg

// [rtl/mpi_port.sv]
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] reset straps pick MII or RMII, 100/10
// [R2] transmit pins in, receive pins out
// [R3] MII nibbles at 2.5 or 25 MHz
// [R4] MII valid and error on both sides
// [R5] collision asserted in half duplex transmit
// [R6] PHY mode faces MAC, MAC mode faces PHY
// [R7] mode flips only clocks, COL, CRS
// [R8] PHY mode drives clocks, COL, CRS, receive group
// [R9] MAC mode takes clocks, COL, CRS as inputs
// [R10] straps on receive data pins at reset
// [R11] RMII: one 50 MHz reference both directions
// [R12] RMII data paths two bits wide
// [R13] normal mode: external reference input used
// [R14] clock mode: drive reference, ignore input
// [R15] RMII no PHY/MAC mode, CRS_DV out
// [R16] RMII toward PHY uses same pins
// [R17] RMII dibit per tick, ten at 10M
module mpi_port (
    input  wire logic                 clk,             // 50 MHz
    input  wire logic                 rstn,            // async, low
    input  wire logic                 wb_cyc_i,        // wishbone cycle
    input  wire logic                 wb_stb_i,        // wishbone strobe
    input  wire logic                 wb_we_i,         // write
    input  wire logic [mpi_pkg::ADR_W-1:0] wb_adr_i,   // byte address
    input  wire logic [3:0]           wb_sel_i,        // byte lanes
    input  wire logic [31:0]          wb_dat_i,        // write data
    output logic      [31:0]          wb_dat_o,        // read data
    output logic                      wb_ack_o,        // acknowledge
    input  wire logic                 eg_valid,        // egress nibble
    output logic                      eg_ready,        // buffer space
    input  wire mpi_pkg::mpi_nib_type eg_data,         // egress nibble
    output logic                      ig_valid,        // ingress pulse
    output mpi_pkg::mpi_nib_type      ig_data,         // ingress nibble
    input  wire logic                 tx_en,           // tx enable pin
    input  wire logic                 tx_er,           // tx error pin
    input  wire logic [3:0]           txd,             // tx data pins
    output logic                      rx_dv,           // rx valid pin
    output logic                      rx_er,           // rx error pin
    input  wire logic [3:0]           rxd_i,           // rxd / straps
    output logic      [3:0]           rxd_o,           // rxd drive
    output logic      [3:0]           rxd_oe,          // rxd enable
    input  wire logic                 ref_clock_in_i,  // tx clk pin in
    output logic                      ref_clock_in_o,  // tx clk drive
    output logic                      ref_clock_in_oe, // tx clk enable
    input  wire logic                 ref_clock_out_i, // rx clk pin in
    output logic                      ref_clock_out_o, // rx clk drive
    output logic                      ref_clock_out_oe,// rx clk enable
    input  wire logic                 col_i,           // collision in
    output logic                      col_o,           // collision out
    output logic                      col_oe,          // collision en
    input  wire logic                 crs_i,           // carrier in
    output logic                      crs_o,           // carrier out
    output logic                      crs_oe,          // carrier en
    input  wire logic                 crystal_input    // 25 MHz xtal
);
    import mpi_pkg::*;

    // ***************************************************************
    // strap capture and port mode
    // ***************************************************************
    mpi_mode_type mode_q;
    logic         speed100_q;
    logic         strap_done_q;
    logic         is_mii;
    logic         is_rmii;
    logic         mii_phy;
    logic         mii_mac;
    logic         active;

    // straps are read on the first edge after release, never under reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_q       <= MD_STRAP;
            speed100_q   <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            speed100_q   <= rxd_i[STRAP_SPEED];                   // [R1]
            if (rxd_i[STRAP_TYPE +: 2] == ITYPE_MII) begin        // [R10]
                mode_q <= rxd_i[STRAP_MODE] ? MD_MII_PHY          // [R6]
                                            : MD_MII_MAC;
            end else if (rxd_i[STRAP_TYPE +: 2] == ITYPE_RMII) begin
                mode_q <= rxd_i[STRAP_MODE] ? MD_RMII_NORM        // [R13]
                                            : MD_RMII_CLK;        // [R14]
            end else begin
                mode_q <= MD_IDLE;
            end
        end
    end

    assign mii_phy = (mode_q == MD_MII_PHY);
    assign mii_mac = (mode_q == MD_MII_MAC);
    assign is_mii  = mii_phy | mii_mac;
    assign is_rmii = (mode_q == MD_RMII_NORM) | (mode_q == MD_RMII_CLK);
    assign active  = is_mii | is_rmii;

    // ***************************************************************
    // line rate divider and link clock edges
    // ***************************************************************
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic [DIV_W-1:0] div_per;
    logic             div_tick;
    logic             lvl_q;
    logic             tin_q;
    logic             rin_q;
    logic             eg_tick;
    logic             ig_tick;

    always_comb begin
        case (mode_q)
            MD_MII_PHY,
            MD_MII_MAC:   div_per = speed100_q ? DIV_W'(DIV_MII100)  // [R3]
                                               : DIV_W'(DIV_MII10);
            MD_RMII_NORM,
            MD_RMII_CLK:  div_per = speed100_q ? DIV_W'(DIV_RMII100) // [R17]
                                               : DIV_W'(DIV_RMII10);
            default:      div_per = DIV_W'(DIV_RMII100);
        endcase
    end

    assign div_tick = active && (cnt_q == '0);
    assign cnt_d    = (cnt_q == '0) ? div_per - 1'b1 : cnt_q - 1'b1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            lvl_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lvl_q <= (cnt_d >= (div_per >> 1));
        end
    end

    // in MAC mode the PHY owns both clocks; their rising edges time us
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tin_q <= 1'b0;
            rin_q <= 1'b0;
        end else begin
            tin_q <= ref_clock_in_i;
            rin_q <= ref_clock_out_i;
        end
    end

    assign ig_tick = mii_mac ? (ref_clock_in_i & ~tin_q) : div_tick; // [R9]
    assign eg_tick = mii_mac ? (ref_clock_out_i & ~rin_q) : div_tick;

    // ***************************************************************
    // rmii reference clock
    // ***************************************************************
    logic refo_q;
    logic xtal_q;
    logic xtal_seen_q;
    logic refin_q;
    logic refin_seen_q;

    // the pad doubler makes the 50 MHz edge; this flop gives its phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refo_q <= 1'b0;
        end else if (mode_q == MD_RMII_CLK) begin
            refo_q <= ~refo_q;                                   // [R14]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xtal_q       <= 1'b0;
            xtal_seen_q  <= 1'b0;
            refin_q      <= 1'b0;
            refin_seen_q <= 1'b0;
        end else begin
            xtal_q  <= crystal_input;
            refin_q <= ref_clock_in_i;
            if (xtal_q != crystal_input) begin
                xtal_seen_q <= 1'b1;
            end
            // the reference input is ignored outside normal mode
            if (mode_q == MD_RMII_NORM && refin_q != ref_clock_in_i) begin
                refin_seen_q <= 1'b1;                            // [R13]
            end
        end
    end

    // ***************************************************************
    // registers
    // ***************************************************************
    logic [2:0]  ctrl_q;
    logic [1:0]  evt_q;
    logic [1:0]  evt_set;
    logic [1:0]  evt_clr;
    logic [15:0] ig_frames_q;
    logic [15:0] eg_frames_q;
    logic        wb_req;
    logic        wb_wr;
    logic [31:0] rd_d;

    assign wb_req  = wb_cyc_i & wb_stb_i;
    assign wb_wr   = wb_req & wb_we_i & wb_ack_o;
    assign evt_clr = (wb_wr && wb_adr_i == REG_EVENT && wb_sel_i[0])
                   ? wb_dat_i[1:0] : 2'h0;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RST;
        end else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[2:0];
        end
    end

    // set beats clear so a same-cycle event is kept
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            evt_q <= 2'h0;
        end else begin
            evt_q <= (evt_q & ~evt_clr) | evt_set;
        end
    end

    always_comb begin
        rd_d = 32'h0;
        if (wb_adr_i == REG_CTRL) begin
            rd_d[2:0] = ctrl_q;
        end else if (wb_adr_i == REG_STATUS) begin
            rd_d[1:0] = is_mii ? ITYPE_MII : (is_rmii ? ITYPE_RMII : 2'h0);
            rd_d[2]   = speed100_q;
            rd_d[3]   = mii_phy | (mode_q == MD_RMII_NORM);
            rd_d[4]   = mii_mac ? crs_i : crs_o;
            rd_d[5]   = mii_mac ? col_i : col_o;
            rd_d[6]   = xtal_seen_q;
            rd_d[7]   = refin_seen_q;
        end else if (wb_adr_i == REG_EVENT) begin
            rd_d[1:0] = evt_q;
        end else if (wb_adr_i == REG_FRAMES) begin
            rd_d = {eg_frames_q, ig_frames_q};
        end
    end

    // one wait state; ack falls the cycle after it was given
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= rd_d;
            end
        end
    end

    // ***************************************************************
    // two-entry egress buffer
    // ***************************************************************
    mpi_nib_type buf_q [2];
    logic        wr_ptr_q;
    logic        rd_ptr_q;
    logic [1:0]  fill_q;
    logic        push;
    logic        pop;
    logic        buf_valid;
    mpi_nib_type head;

    assign eg_ready  = (fill_q != 2'h2);
    assign buf_valid = (fill_q != 2'h0);
    assign push      = eg_valid & eg_ready;
    assign head      = buf_q[rd_ptr_q];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fill_q   <= 2'h0;
        end else begin
            if (push) begin
                buf_q[wr_ptr_q] <= eg_data;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ***************************************************************
    // egress: receive-named pins carry data out
    // ***************************************************************
    logic       eg_go;
    logic       eg_ph_q;
    logic [3:0] rxd_q;
    logic       rx_dv_q;
    logic       rx_er_q;

    assign eg_go = eg_tick & ctrl_q[CTRL_EG_EN];
    assign pop   = eg_go & buf_valid & (is_mii | eg_ph_q);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxd_q       <= 4'h0;
            rx_dv_q     <= 1'b0;
            rx_er_q     <= 1'b0;
            eg_ph_q     <= 1'b0;
            eg_frames_q <= 16'h0;
        end else if (eg_go) begin
            rx_dv_q <= buf_valid;                                 // [R2]
            rx_er_q <= buf_valid & head.err;                      // [R4]
            if (!buf_valid) begin
                rxd_q   <= 4'h0;
                eg_ph_q <= 1'b0;
            end else if (is_mii) begin
                rxd_q <= head.data;                               // [R3]
            end else if (!eg_ph_q) begin
                rxd_q   <= {2'h0, head.data[1:0]};                // [R12]
                eg_ph_q <= 1'b1;                                  // [R17]
            end else begin
                rxd_q   <= {2'h0, head.data[3:2]};
                eg_ph_q <= 1'b0;
            end
            if (pop && head.last) begin
                eg_frames_q <= eg_frames_q + 16'h1;
            end
        end else if (!ctrl_q[CTRL_EG_EN]) begin
            rx_dv_q <= 1'b0;
            rx_er_q <= 1'b0;
        end
    end

    assign rxd_o  = rxd_q;
    assign rx_dv  = rx_dv_q;                                      // [R15]
    assign rx_er  = rx_er_q;
    assign rxd_oe = !strap_done_q ? OE_NONE                       // [R10]
                  : is_mii        ? OE_MII
                  : is_rmii       ? OE_RMII : OE_NONE;            // [R7]

    // ***************************************************************
    // ingress: transmit-named pins carry data in
    // ***************************************************************
    logic       ig_go;
    logic       ten_q;
    logic       sof_q;
    logic       ig_ph_q;
    logic [1:0] ig_lo_q;

    assign ig_go = ig_tick & ctrl_q[CTRL_IG_EN];

    // in RMII the enable pin is tx_en, CRS_DV goes out on rx_dv; low dibit arrives first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ig_valid    <= 1'b0;
            ig_data     <= '0;
            ten_q       <= 1'b0;
            sof_q       <= 1'b0;
            ig_ph_q     <= 1'b0;
            ig_lo_q     <= 2'h0;
            ig_frames_q <= 16'h0;
        end else begin
            ig_valid <= 1'b0;
            if (ig_go) begin
                ten_q <= tx_en;
                if (tx_en && !ten_q) begin
                    ig_frames_q <= ig_frames_q + 16'h1;
                end
                if (!tx_en) begin
                    ig_ph_q <= 1'b0;
                    sof_q   <= 1'b1;
                end else if (is_mii) begin
                    ig_valid <= 1'b1;                             // [R4]
                    ig_data  <= '{sof: sof_q, last: 1'b0,
                                  err: tx_er, data: txd};         // [R2]
                    sof_q    <= 1'b0;
                end else if (!ig_ph_q) begin
                    ig_lo_q <= txd[1:0];                          // [R12]
                    ig_ph_q <= 1'b1;
                end else begin
                    ig_valid <= 1'b1;                             // [R16]
                    ig_data  <= '{sof: sof_q, last: 1'b0, err: 1'b0,
                                  data: {txd[1:0], ig_lo_q}};
                    ig_ph_q  <= 1'b0;
                    sof_q    <= 1'b0;
                end
            end
        end
    end

    // ***************************************************************
    // carrier, collision and clock pins
    // ***************************************************************
    logic crs_q;
    logic col_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            crs_q <= 1'b0;
            col_q <= 1'b0;
        end else begin
            crs_q <= mii_phy & (rx_dv_q | ten_q);                 // [R8]
            col_q <= mii_phy & ctrl_q[CTRL_HALF]                  // [R5]
                   & rx_dv_q & ten_q;
        end
    end

    assign evt_set[EVT_COL] = ctrl_q[CTRL_HALF] & rx_dv_q
                            & (mii_mac ? col_i : col_q);
    assign evt_set[EVT_ERR] = ig_go & is_mii & tx_en & tx_er;

    assign crs_o            = crs_q;
    assign col_o            = col_q;
    assign crs_oe           = mii_phy;                            // [R7]
    assign col_oe           = mii_phy;
    assign ref_clock_in_o   = lvl_q;
    assign ref_clock_in_oe  = mii_phy;                            // [R8]
    assign ref_clock_out_o  = mii_phy ? lvl_q : refo_q;
    assign ref_clock_out_oe = mii_phy | (mode_q == MD_RMII_CLK);  // [R11]

    // ***************************************************************
    // checks
    // ***************************************************************
    a_strap_release: assert property (@(posedge clk) disable iff (!rstn)
        !strap_done_q |-> rxd_oe == OE_NONE) // [R10]
        else $error("rxd driven during strap sampling");

    a_phy_clock_dir: assert property (@(posedge clk) disable iff (!rstn)
        mii_phy |-> ref_clock_in_oe && ref_clock_out_oe && col_oe
                    && crs_oe) // [R8]
        else $error("phy mode not driving clocks, col, crs");

    a_mac_clock_dir: assert property (@(posedge clk) disable iff (!rstn)
        mii_mac |-> !ref_clock_in_oe && !ref_clock_out_oe && !col_oe
                    && !crs_oe && rxd_oe == OE_MII) // [R9]
        else $error("mac mode direction wrong");

    a_clock_mode_ref: assert property (@(posedge clk) disable iff (!rstn)
        mode_q == MD_RMII_CLK |-> ref_clock_out_oe && !ref_clock_in_oe
        ##1 ref_clock_out_o != $past(ref_clock_out_o)) // [R14]
        else $error("clock mode reference not driven");

    a_mii100_rate: assert property (@(posedge clk) disable iff (!rstn)
        mii_phy && speed100_q && div_tick |=> !div_tick ##1 div_tick)
        // [R3]
        else $error("25 MHz nibble rate wrong");

    a_rmii10_hold: assert property (@(posedge clk) disable iff (!rstn)
        is_rmii && !speed100_q && div_tick |=> !div_tick[*8]
        ##1 !div_tick ##1 div_tick) // [R17]
        else $error("10M dibit not held ten cycles");

    a_rmii_width: assert property (@(posedge clk) disable iff (!rstn)
        is_rmii |-> rxd_oe == OE_RMII && rxd_o[3:2] == 2'h0) // [R12]
        else $error("rmii data wider than two bits");

    a_col_half: assert property (@(posedge clk) disable iff (!rstn)
        mii_phy && ctrl_q[CTRL_HALF] && $stable(ctrl_q) && rx_dv_q
        && ten_q |=> col_o) // [R5]
        else $error("collision not flagged in half duplex");

    a_col_full: assert property (@(posedge clk) disable iff (!rstn)
        col_o |-> $past(ctrl_q[CTRL_HALF])) // [R5]
        else $error("collision in full duplex");

    a_ingress_nib: assert property (@(posedge clk) disable iff (!rstn)
        mii_phy && ig_go && tx_en |=> ig_valid
        && ig_data.data == $past(txd) && ig_data.err == $past(tx_er))
        // [R4]
        else $error("ingress nibble lost");

endmodule : mpi_port

`default_nettype wire

// [verif/mpi_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
// far-end mac: holds straps, resolves rxd pins, takes egress nibbles
module mpi_far_end (
    input  wire logic       clk,     // system clock
    input  wire logic       rstn,    // async, low
    input  wire logic [3:0] strap,   // reset levels
    input  wire logic [3:0] rxd_o,   // device drive
    input  wire logic [3:0] rxd_oe,  // device enable
    input  wire logic       rclk,    // rx clock pin
    input  wire logic       rx_dv,   // rx valid pin
    output logic      [3:0] rxd_pin, // resolved rxd
    output logic      [3:0] got_q,   // last nibble
    output logic      [7:0] cnt_q    // nibbles seen
);
    logic held_q;
    logic rclk_q;
    // no pull: an undriven line shows the inverse of the drive
    assign rxd_pin = held_q ? ((rxd_oe & rxd_o) | (~rxd_oe & ~rxd_o))
                            : strap;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held_q <= 1'b0;
            rclk_q <= 1'b0;
            got_q  <= 4'h0;
            cnt_q  <= 8'h0;
        end else begin
            held_q <= 1'b1;
            rclk_q <= rclk;
            if (rclk && !rclk_q && rx_dv) begin
                got_q <= rxd_pin;
                cnt_q <= cnt_q + 8'h1;
            end
        end
    end
endmodule : mpi_far_end
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb;
    import mpi_pkg::*;
    logic clk = 0, rstn = 0, xtal = 0, cyc = 0, stb = 0, wen = 0, ack;
    logic egv = 0, egr, igv, tx_en = 0, rx_dv, rx_er, col = 0, ter = 0;
    logic [7:0] adr = 8'h0, cnt;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0] txd = 4'h0, strap = 4'h0, rxd_o, rxd_oe, pin, got;
    logic ci_o, ci_oe, co_o, co_oe, col_o, col_oe, crs_o, crs_oe;
    mpi_nib_type egd = '0, igd;
    int bad_count = 0, compares = 0;
    always #10 clk = ~clk;
    always #20 xtal = ~xtal;
    mpi_port dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .eg_valid(egv), .eg_ready(egr),
        .eg_data(egd), .ig_valid(igv), .ig_data(igd), .tx_en(tx_en),
        .tx_er(ter), .txd(txd), .rx_dv(rx_dv), .rx_er(rx_er),
        .rxd_i(pin), .rxd_o(rxd_o), .rxd_oe(rxd_oe),
        .ref_clock_in_i(ci_oe ? ci_o : xtal), .ref_clock_in_o(ci_o),
        .ref_clock_in_oe(ci_oe), .ref_clock_out_i(co_oe ? co_o : xtal),
        .ref_clock_out_o(co_o), .ref_clock_out_oe(co_oe), .col_i(col),
        .col_o(col_o), .col_oe(col_oe), .crs_i(col), .crs_o(crs_o),
        .crs_oe(crs_oe), .crystal_input(xtal));
    mpi_far_end far_u (.clk(clk), .rstn(rstn), .strap(strap), .rxd_o(rxd_o),
        .rxd_oe(rxd_oe), .rclk(co_oe ? co_o : xtal), .rx_dv(rx_dv),
        .rxd_pin(pin), .got_q(got), .cnt_q(cnt));
    task automatic summarize();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    task automatic bound(input int n);
        if (n >= 500) begin
            bad_count++;
            summarize();
        end
    endtask : bound
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1; stb <= 1'b1; wen <= w; adr <= a; wdat <= d;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 500);
        bound(n);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic push(input logic [3:0] v);
        int n = 0;
        egv <= 1'b1; egd <= '{1'b0, 1'b0, 1'b0, v};
        do begin @(posedge clk); n++; end while (egr !== 1'b1 && n < 500);
        bound(n);
        egv <= 1'b0;
        @(posedge clk);
    endtask : push
    task automatic wait_cnt(input logic [7:0] k);
        int n = 0;
        while (cnt !== k && n < 500) begin @(posedge clk); n++; end
        bound(n);
    endtask : wait_cnt
    // ingress pulse spacing; sof must mark only the first nibble
    task automatic gap(input int e, input logic [3:0] v);
        int n = 0;
        tx_en <= 1'b1; txd <= v;
        while (igv !== 1'b1 && n < 500) begin @(posedge clk); n++; end
        bound(n);
        `CHK(igd.sof, 1'b1)
        n = 0;
        do begin @(posedge clk); n++; end while (igv !== 1'b1 && n < 500);
        bound(n);
        `CHK(n, e)
        `CHK(igd, {2'h0, ter, 4'h5})
        `CHK(crs_o, crs_oe)
        tx_en <= 1'b0;
        ter <= 1'b0;
    endtask : gap
    task automatic restart(input logic [3:0] s);
        strap <= s; rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : restart
    task automatic t_mii_phy();
        restart(4'h7);
        `CHK({ci_oe, co_oe, col_oe, crs_oe, rxd_oe}, 8'hff)
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK(q[2:0], CTRL_RST)
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(q[3:0], 4'hd)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        wb(1'b1, REG_CTRL, 32'h2);
        push(4'h9);
        push(4'h6);
        `CHK(egr, 1'b0)
        wb(1'b1, REG_CTRL, 32'h3);
        wait_cnt(8'h1);
        `CHK(got, 4'h9)
        wait_cnt(8'h2);
        `CHK(got, 4'h6)
        ter <= 1'b1;
        gap(2, 4'h5);
        wb(1'b0, REG_EVENT, 32'h0);
        `CHK(q[EVT_ERR], 1'b1)
        wb(1'b0, REG_FRAMES, 32'h0);
        `CHK(q, 32'h1)
        $display("mii phy mode done");
    endtask : t_mii_phy
    task automatic t_mii_mac();
        restart(4'h5);
        `CHK({ci_oe, co_oe, col_oe, crs_oe, rxd_oe}, 8'h0f)
        wb(1'b1, REG_CTRL, 32'h7);
        col <= 1'b1;
        push(4'h3);
        wait_cnt(8'h1);
        col <= 1'b0;
        wb(1'b0, REG_EVENT, 32'h0);
        `CHK(q[EVT_COL], 1'b1)
        wb(1'b1, REG_EVENT, 32'h1);
        wb(1'b0, REG_EVENT, 32'h0);
        `CHK(q[EVT_COL], 1'b0)
        gap(2, 4'h5);
        $display("mii mac mode done");
    endtask : t_mii_mac
    task automatic t_rmii();
        logic p;
        restart(4'h6);
        gap(20, 4'h5);
        restart(4'h8);
        `CHK({ci_oe, co_oe, rxd_oe}, {2'b01, OE_RMII})
        p = co_o;
        @(posedge clk);
        `CHK(co_o, ~p)
        gap(20, 4'h1);
        restart(4'hb);
        `CHK({ci_oe, co_oe}, 2'b00)
        gap(2, 4'h1);
        wb(1'b0, REG_STATUS, 32'h0);
        `CHK(q[7:0], 8'hce)
        restart(4'h0);
        `CHK(rxd_oe, OE_NONE)
        $display("rmii modes done");
    endtask : t_rmii
    initial begin
        t_mii_phy();
        t_mii_mac();
        t_rmii();
        summarize();
    end
endmodule : tb
`default_nettype wire
